// ### rtl/pirq_pkg.sv
/*
  Constants, register map and carrier types for the peripheral interrupt flag block.
  Assumes a 32-bit APB master on the same clock and peripherals that drive event pulses and buffer levels.
*/
package pirq_pkg;
  // Bus geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h008;

  // Flag register field positions.
  localparam int BIT_UNUSED = 7;
  localparam int BIT_CONV = 6;
  localparam int BIT_RX = 5;
  localparam int BIT_TX = 4;
  localparam int BIT_SYNC = 3;
  localparam int BIT_CAPCMP = 2;
  localparam int BIT_TMRB = 1;
  localparam int BIT_TMRA = 0;

  // Control register width and field positions.
  localparam int CTRL_W = 2;
  localparam int BIT_PERIPH_EN = 0;
  localparam int BIT_PRIO_EN = 1;

  // Reset values and masks.
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam logic [FLAG_W-1:0] ENABLE_MASK = 8'h7f;
  localparam logic [FLAG_W-1:0] STICKY_MASK = 8'h4f;

  // One-cycle event pulses from the peripherals.
  typedef struct packed {
    logic conv_done;
    logic sync_port_done;
    logic capcmp_match;
    logic timer_b_match;
    logic timer_a_overflow;
  } periph_events_t;

  // Buffer state levels from the serial port.
  typedef struct packed {
    logic rx_full;
    logic tx_empty;
  } buffer_levels_t;
endpackage

// ### rtl/periph_irq_flags.sv
/*
  Peripheral interrupt request flag register with its enable mask, control bits,
  APB slave and one level interrupt output.
  Assumes event pulses and buffer levels come from logic on clk; the APB master runs on clk.
  Event pulses last one cycle each; a longer level simply sets its flag again every cycle.
  Software owns the enable and control words; nothing in here writes them on its own.
*/
// Added by the designer: the APB interface to the registers and the placing of the registers.
// How it works
// (RULE_01) Flags set on their condition whatever the enable and global enable bits say.
// (RULE_02) Software clears a flag before enabling its source and after servicing it.
// (RULE_03) Converter flag bit 6 sets on conversion done, holds until written zero.
// (RULE_04) Receive flag bit 5 is read-only and mirrors receive buffer full.
// (RULE_05) Transmit flag bit 4 is read-only and mirrors transmit buffer empty.
// (RULE_06) Sync port flag bit 3 sets on transfer complete, holds until software clears.
// (RULE_07) Capture/compare flag bit 2 sets on compare match, holds until cleared.
// (RULE_08) Timer-b flag bit 1 sets on period match, holds until cleared.
// (RULE_09) Timer-a flag bit 0 sets on overflow, holds until written zero.
// (RULE_10) Without priority levels, interrupts pass only when the peripheral enable is set.
// (RULE_11) Bit 7 reads zero and ignores writes; all flags read zero after reset.
`timescale 1ns/1ns
module periph_irq_flags (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pirq_pkg::ADDR_W-1:0] paddr,
  input wire logic [pirq_pkg::DATA_W-1:0] pwdata,
  output logic [pirq_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral conditions.
  input wire pirq_pkg::periph_events_t events,
  input wire pirq_pkg::buffer_levels_t levels,
  // Interrupt request.
  output logic irq
);
  import pirq_pkg::*;

  // Register map, one aligned word per register, unused upper bits read as zero.
  // The flag word at OFS_FLAGS holds five sticky requests, two serial buffer bits and bit 7.
  // A sticky request clears only when software writes a zero over it.
  // Writing a one to a sticky request raises it, which lets software test its handler.
  // A set condition and a clearing write in the same cycle leave the request set, so an
  // event that lands while software clears the bit is never lost.
  // The two serial bits copy their buffer levels one cycle late and ignore writes.
  // They fall when the serial block reports its receive buffer read or its transmit buffer filled.
  // Bit 7 has no source; it reads zero whatever is written.
  // The enable word at OFS_ENABLE masks the flags bit for bit; its bit 7 is held at zero.
  // The control word at OFS_CTRL holds the peripheral enable and the priority levels enable.
  // Read data and the error flag are captured in the setup cycle, so a read shows the flags
  // as they stood one cycle before its access edge; a later event shows on the next read.
  // Every access completes without wait states, and an unmapped offset answers with an
  // error and zero data while changing nothing.
  // The interrupt output is combinational from registers only, so it never glitches on
  // bus inputs and moves one cycle after the write or event that causes it.

  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] flags_next;
  logic [FLAG_W-1:0] enable_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pslverr_reg;
  logic setup;
  logic access;
  logic wr_flags;
  logic wr_enable;
  logic wr_ctrl;
  logic [FLAG_W-1:0] set_vec;
  logic [FLAG_W-1:0] base_vec;
  logic irq_gate;

  // Tells whether an address falls on a mapped register.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_FLAGS) || (a == OFS_ENABLE) || (a == OFS_CTRL);
  endfunction

  // Bus phases; every access completes with no wait state.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign wr_flags = access && pwrite && (paddr == OFS_FLAGS);
  assign wr_enable = access && pwrite && (paddr == OFS_ENABLE);
  assign wr_ctrl = access && pwrite && (paddr == OFS_CTRL);

  // Gathers the sticky set conditions; no enable takes part in them.
  always_comb begin
    set_vec = '0; // RULE_01
    set_vec[BIT_CONV] = events.conv_done; // RULE_03
    set_vec[BIT_SYNC] = events.sync_port_done; // RULE_06
    set_vec[BIT_CAPCMP] = events.capcmp_match; // RULE_07
    set_vec[BIT_TMRB] = events.timer_b_match; // RULE_08
    set_vec[BIT_TMRA] = events.timer_a_overflow; // RULE_09
  end

  // A write replaces the sticky bits, then a set in the same cycle wins over a zero written.
  always_comb begin
    base_vec = wr_flags ? pwdata[FLAG_W-1:0] : flags_reg;
    flags_next = (base_vec | set_vec) & STICKY_MASK; // RULE_03 RULE_06 RULE_07 RULE_08 RULE_09
    flags_next[BIT_RX] = levels.rx_full; // RULE_04
    flags_next[BIT_TX] = levels.tx_empty; // RULE_05
    flags_next[BIT_UNUSED] = 1'b0; // RULE_11
  end

  // Flag register; buffer bits follow their level one cycle later.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= FLAGS_RESET; // RULE_11
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Enable mask register, same layout as the flags.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= ENABLE_RESET;
    end else if (wr_enable) begin
      enable_reg <= pwdata[FLAG_W-1:0] & ENABLE_MASK;
    end
  end

  // Control register: peripheral enable and priority levels enable.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[CTRL_W-1:0];
    end
  end

  // Read data and error are captured in the setup cycle so they come from flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      pslverr_reg <= !is_mapped(paddr);
      unique case (paddr)
        OFS_FLAGS: prdata_reg <= {{(DATA_W-FLAG_W){1'b0}}, flags_reg};
        OFS_ENABLE: prdata_reg <= {{(DATA_W-FLAG_W){1'b0}}, enable_reg};
        OFS_CTRL: prdata_reg <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
        default: prdata_reg <= '0;
      endcase
    end
  end

  // Interrupt: any enabled flag, gated by the peripheral enable unless priority levels are on.
  assign irq_gate = ctrl_reg[BIT_PRIO_EN] || ctrl_reg[BIT_PERIPH_EN]; // RULE_10
  assign irq = irq_gate && |(flags_reg & enable_reg); // RULE_10

  // Checks on the design's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A flags write that puts zero on one bit.
  sequence flag_zeroed(int b);
    wr_flags && !pwdata[b] && !set_vec[b];
  endsequence

  a_conv_set: assert property (events.conv_done |=> flags_reg[BIT_CONV]) // RULE_03
    else $error("converter flag missed its event");
  a_conv_hold: assert property (flags_reg[BIT_CONV] && !wr_flags |=> flags_reg[BIT_CONV]) // RULE_03
    else $error("converter flag dropped without a write");
  a_conv_clear: assert property (flag_zeroed(BIT_CONV) |=> !flags_reg[BIT_CONV]) // RULE_03
    else $error("converter flag not cleared by write of zero");
  a_rx_follow: assert property (1'b1 |=> flags_reg[BIT_RX] == $past(levels.rx_full)) // RULE_04
    else $error("receive flag does not mirror buffer");
  a_tx_follow: assert property (1'b1 |=> flags_reg[BIT_TX] == $past(levels.tx_empty)) // RULE_05
    else $error("transmit flag does not mirror buffer");
  a_sync_set: assert property (events.sync_port_done |=> flags_reg[BIT_SYNC] [*1]) // RULE_06
    else $error("sync port flag missed its event");
  a_capcmp_set: assert property (events.capcmp_match && wr_flags |=> flags_reg[BIT_CAPCMP]) // RULE_07
    else $error("compare flag lost to a clearing write");
  a_tmrb_keep: assert property (flags_reg[BIT_TMRB] && !wr_flags |=> flags_reg[BIT_TMRB]) // RULE_08
    else $error("timer-b flag dropped without a write");
  a_tmra_clear: assert property (flag_zeroed(BIT_TMRA) |=> !flags_reg[BIT_TMRA]) // RULE_09
    else $error("timer-a flag not cleared by write of zero");
  a_irq_gate: assert property (!ctrl_reg[BIT_PRIO_EN] && !ctrl_reg[BIT_PERIPH_EN] |-> !irq) // RULE_10
    else $error("interrupt passed with peripheral enable off");
  a_irq_cause: assert property ($rose(irq) |-> $past(wr_enable || wr_ctrl || (flags_next != flags_reg))) // RULE_10
    else $error("interrupt rose with no write and no new flag");
  a_bit7_zero: assert property (!flags_reg[BIT_UNUSED]) // RULE_11
    else $error("unimplemented flag bit is set");

  // A write landing on the given register in its access cycle.
  sequence reg_written(logic [ADDR_W-1:0] ofs);
    access && pwrite && (paddr == ofs);
  endsequence

  // A setup cycle that names the given register.
  sequence setup_at(logic [ADDR_W-1:0] ofs);
    setup && (paddr == ofs);
  endsequence

  // A sticky flag that stands while nothing writes the flag register.
  sequence flag_left(int b);
    flags_reg[b] && !wr_flags;
  endsequence

  // A write that puts a one on a sticky bit.
  sequence flag_forced(int b);
    wr_flags && pwdata[b];
  endsequence

  // The sync port flag keeps its request until software writes a zero over it.
  a_sync_hold: assert property (flag_left(BIT_SYNC) |=> flags_reg[BIT_SYNC]) // RULE_06
    else $error("sync port flag dropped without a write");
  a_sync_clear: assert property (flag_zeroed(BIT_SYNC) |=> !flags_reg[BIT_SYNC]) // RULE_06
    else $error("sync port flag not cleared by write of zero");

  // The compare flag rises on a match and stays until a zero is written.
  a_capcmp_hit: assert property (events.capcmp_match |=> flags_reg[BIT_CAPCMP]) // RULE_07
    else $error("compare flag missed its event");
  a_capcmp_hold: assert property (flag_left(BIT_CAPCMP) |=> flags_reg[BIT_CAPCMP]) // RULE_07
    else $error("compare flag dropped without a write");
  a_capcmp_clear: assert property (flag_zeroed(BIT_CAPCMP) |=> !flags_reg[BIT_CAPCMP]) // RULE_07
    else $error("compare flag not cleared by write of zero");

  // The timer-b flag follows the same set and clear steps, and rises again after a clear.
  a_tmrb_set: assert property (events.timer_b_match |=> flags_reg[BIT_TMRB]) // RULE_08
    else $error("timer-b flag missed its event");
  a_tmrb_clear: assert property (flag_zeroed(BIT_TMRB) |=> !flags_reg[BIT_TMRB]) // RULE_08
    else $error("timer-b flag not cleared by write of zero");
  a_tmrb_rearm: assert property (flag_zeroed(BIT_TMRB) ##1 events.timer_b_match |=> flags_reg[BIT_TMRB]) // RULE_08
    else $error("timer-b flag did not rise again after a clear");

  // The timer-a flag rises on overflow and holds without a write.
  a_tmra_set: assert property (events.timer_a_overflow |=> flags_reg[BIT_TMRA]) // RULE_09
    else $error("timer-a flag missed its event");
  a_tmra_hold: assert property (flag_left(BIT_TMRA) |=> flags_reg[BIT_TMRA]) // RULE_09
    else $error("timer-a flag dropped without a write");

  // A set condition wins over a clearing write in the same cycle.
  a_conv_wins: assert property (wr_flags && events.conv_done |=> flags_reg[BIT_CONV]) // RULE_03
    else $error("converter event lost to a write");
  a_sync_wins: assert property (wr_flags && events.sync_port_done |=> flags_reg[BIT_SYNC]) // RULE_06
    else $error("sync port event lost to a write");
  a_tmra_wins: assert property (wr_flags && events.timer_a_overflow |=> flags_reg[BIT_TMRA]) // RULE_09
    else $error("timer-a event lost to a write");

  // Every set condition shows in the flags one cycle later, whatever the enables hold.
  a_set_any: assert property (1'b1 |=> (flags_reg & $past(set_vec)) == $past(set_vec)) // RULE_01
    else $error("a set condition did not reach its flag");
  a_set_masked: assert property (events.conv_done && !enable_reg[BIT_CONV] |=> flags_reg[BIT_CONV]) // RULE_01
    else $error("converter flag waited for its enable");

  // The serial bits ignore writes and keep copying their buffer levels.
  a_rx_nowrite: assert property (wr_flags |=> flags_reg[BIT_RX] == $past(levels.rx_full)) // RULE_04
    else $error("receive flag moved by a write");
  a_tx_nowrite: assert property (wr_flags |=> flags_reg[BIT_TX] == $past(levels.tx_empty)) // RULE_05
    else $error("transmit flag moved by a write");

  // Every access answers at once, with data captured in its setup cycle.
  a_ready_high: assert property (pready)
    else $error("access held in a wait state");
  a_read_flags: assert property (setup_at(OFS_FLAGS) |=> prdata == DATA_W'($past(flags_reg))) // RULE_11
    else $error("flag read returned the wrong word");
  a_read_enable: assert property (setup_at(OFS_ENABLE) |=> prdata == DATA_W'($past(enable_reg))) // RULE_10
    else $error("enable read returned the wrong word");
  a_read_ctrl: assert property (setup_at(OFS_CTRL) |=> prdata == DATA_W'($past(ctrl_reg))) // RULE_10
    else $error("control read returned the wrong word");

  // Unmapped offsets answer with an error and zero data; mapped ones answer cleanly.
  a_err_unmapped: assert property (setup && !is_mapped(paddr) |=> pslverr && (prdata == '0))
    else $error("unmapped offset answered without an error");
  a_err_mapped: assert property (setup && is_mapped(paddr) |=> !pslverr)
    else $error("mapped offset answered with an error");
  a_stray_quiet: assert property (setup && !is_mapped(paddr) ##1 access && pwrite
    |=> $stable(enable_reg) && $stable(ctrl_reg))
    else $error("write to an unmapped offset changed a register");

  // The enable word takes the written mask, keeps it otherwise and never holds bit 7.
  a_enable_write: assert property (reg_written(OFS_ENABLE) // RULE_10
    |=> enable_reg == ($past(pwdata[FLAG_W-1:0]) & ENABLE_MASK))
    else $error("enable write did not land");
  a_enable_keep: assert property (!wr_enable |=> $stable(enable_reg)) // RULE_10
    else $error("enable word changed without a write");
  a_enable_bit7: assert property (!enable_reg[BIT_UNUSED])
    else $error("unimplemented enable bit is set");

  // The control word takes what is written and keeps it otherwise.
  a_ctrl_write: assert property (reg_written(OFS_CTRL) |=> ctrl_reg == $past(pwdata[CTRL_W-1:0])) // RULE_10
    else $error("control write did not land");
  a_ctrl_keep: assert property (!wr_ctrl |=> $stable(ctrl_reg)) // RULE_10
    else $error("control word changed without a write");

  // An enabled flag reaches the output through either gate, and nothing else does.
  a_irq_prio: assert property (ctrl_reg[BIT_PRIO_EN] && |(flags_reg & enable_reg) |-> irq) // RULE_10
    else $error("interrupt held back with priority levels on");
  a_irq_periph: assert property (ctrl_reg[BIT_PERIPH_EN] && |(flags_reg & enable_reg) |-> irq) // RULE_10
    else $error("interrupt held back with peripheral enable on");
  a_irq_off: assert property (!(|(flags_reg & enable_reg)) |-> !irq) // RULE_10
    else $error("interrupt without an enabled flag");

  // Writing a one raises a sticky request by hand.
  a_forced_conv: assert property (flag_forced(BIT_CONV) |=> flags_reg[BIT_CONV])
    else $error("converter flag not raised by write of one");
  a_forced_tmra: assert property (flag_forced(BIT_TMRA) |=> flags_reg[BIT_TMRA])
    else $error("timer-a flag not raised by write of one");
endmodule // periph_irq_flags

// ### verif/periph_model.sv
/*
  Peripheral model: turns bench requests into event pulses and serial buffer levels.
  Assumes requests arrive on clk and last one cycle.
*/
`timescale 1ns/1ns
module periph_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Requests: events, then rx arrive, rx read, tx sent, tx write.
  input wire logic [4:0] ev_req,
  input wire logic [3:0] buf_req,
  // Conditions to the flag block.
  output pirq_pkg::periph_events_t events,
  output pirq_pkg::buffer_levels_t levels
);
  import pirq_pkg::*;
  // Each event request becomes a one-cycle pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      events <= '0;
    end else begin
      events <= ev_req;
    end
  end
  // Buffers start with rx not full and tx not empty; a read empties rx and a write fills tx.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      levels <= '0;
    end else begin
      levels.rx_full <= buf_req[3] | (levels.rx_full & ~buf_req[2]);
      levels.tx_empty <= buf_req[1] | (levels.tx_empty & ~buf_req[0]);
    end
  end
endmodule // periph_model

// ### verif/testbench.sv
/*
  Self-checking bench for the peripheral interrupt flag block.
  Assumes an APB slave that answers with pready and the peripheral model feeding it.
*/
`timescale 1ns/1ns
module testbench;
  import pirq_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [4:0] ev_req;
  logic [3:0] buf_req;
  periph_events_t events;
  buffer_levels_t levels;
  int bad_count = 0;
  int tests_run = 0;
  // Rows: event request, buffer request, expected flags with all enables off.
  logic [16:0] rows [8] = '{{5'h10, 4'h0, 8'h40}, {5'h08, 4'h0, 8'h08}, {5'h04, 4'h0, 8'h04},
    {5'h02, 4'h0, 8'h02}, {5'h01, 4'h0, 8'h01}, {5'h00, 4'h8, 8'h20}, {5'h00, 4'h2, 8'h10}, {5'h00, 4'h0, 8'h00}};
  periph_irq_flags uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events), .levels(levels), .irq(irq));
  periph_model model (.clk(clk), .rst(rst), .ev_req(ev_req), .buf_req(buf_req), .events(events), .levels(levels));
  // Clock of 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // One APB transfer; read data and error are taken at the edge where pready is seen.
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(1'b0, a, '0);
    chk(nm, e, rd);
  endtask
  // Irq is looked at on the falling edge after the last write has landed, where it is settled.
  task irqchk(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task pulse(input logic [4:0] e, input logic [3:0] b);
    @(posedge clk);
    ev_req <= e;
    buf_req <= b;
    @(posedge clk);
    ev_req <= '0;
    buf_req <= '0;
    repeat (2) @(posedge clk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence: table rows, then sticky, irq, unmapped and reset cases.
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, ev_req, buf_req} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, OFS_FLAGS, '0);
      pulse(rows[i][16:12], rows[i][11:8]);
      rdchk("flags", OFS_FLAGS, {24'h0, rows[i][7:0]});
      pulse(5'h00, 4'h5);
    end
    apb(1'b1, OFS_FLAGS, 32'hff);
    rdchk("flags", OFS_FLAGS, 32'h4f);
    apb(1'b1, OFS_FLAGS, 32'h0f);
    rdchk("flags", OFS_FLAGS, 32'h0f);
    apb(1'b1, OFS_ENABLE, 32'hff);
    rdchk("enable", OFS_ENABLE, 32'h7f);
    apb(1'b1, OFS_ENABLE, 32'h01);
    irqchk(1'b0);
    apb(1'b1, OFS_CTRL, 32'h01);
    irqchk(1'b1);
    apb(1'b1, OFS_FLAGS, 32'h0e);
    irqchk(1'b0);
    apb(1'b1, OFS_CTRL, 32'h02);
    pulse(5'h01, 4'h0);
    irqchk(1'b1);
    apb(1'b1, OFS_ENABLE, 32'h00);
    irqchk(1'b0);
    // A compare match lands on the very edge of a clearing write; the set must win.
    fork
      apb(1'b1, OFS_FLAGS, 32'h0);
      begin
        @(posedge clk);
        ev_req <= 5'h04;
        @(posedge clk);
        ev_req <= '0;
      end
    join
    rdchk("flags", OFS_FLAGS, 32'h04);
    rdchk("unmapped", 12'h00c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk("flags", OFS_FLAGS, 32'h0);
    rdchk("ctrl", OFS_CTRL, 32'h0);
    chk("pslverr", 32'h0, {31'h0, err});
    chk("pready", 32'h1, {31'h0, pready});
    print_verdict();
  end
  // The run needs about 180 cycles; ten thousand marks a hang.
  initial begin
    #80000;
    bad_count++;
    print_verdict();
  end
endmodule // testbench
